// ### prmc_asserts.sv
/*
 * checker for the proximity readout block: run timing, led drive and
 * bus pin behaviour, seen only through the top module's ports.
 * assumes one clock domain and an active-low asynchronous reset.
 */
`timescale 1ns/1ns
`default_nettype none

module prmc_asserts #(
    parameter integer MEAS_CYCLES = 4096
) (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // measurement and optics
    input wire logic meas_start,
    input wire logic meas_busy,
    input wire logic meas_done,
    input wire logic ir_led,
    input wire logic ir_rx
);
    logic [15:0] run_cnt_reg; // cycles since a run was taken

    // counts from the accepted start so the done pulse can be timed
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            run_cnt_reg <= 16'h0000;
        end else if (meas_start && !meas_busy) begin
            run_cnt_reg <= 16'h0000;
        end else begin
            run_cnt_reg <= run_cnt_reg + 16'h0001;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence s_taken;
        meas_start && !meas_busy;
    endsequence
    sequence s_run_on;
        meas_busy && ir_led;
    endsequence

    property p_run_start;
        s_taken |=> s_run_on;
    endproperty
    a_run_start: assert property (p_run_start) else $error("run did not start");
    property p_led_idle;
        !meas_busy && !$past(meas_busy) |-> !ir_led;
    endproperty
    a_led_idle: assert property (p_led_idle) else $error("led driven outside run");
    property p_done_len;
        meas_done |-> run_cnt_reg == MEAS_CYCLES;
    endproperty
    a_done_len: assert property (p_done_len) else $error("run length wrong");
    property p_done_pulse;
        meas_done |=> !meas_done;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done longer than a cycle");
    property p_done_busy;
        meas_done |-> $past(meas_busy);
    endproperty
    a_done_busy: assert property (p_done_busy) else $error("done without run");
    property p_led_hold;
        $rose(ir_led) |=> ir_led [*8];
    endproperty
    a_led_hold: assert property (p_led_hold) else $error("led half period short");
    property p_ack_scl_low;
        $rose(sda_oe) |-> !scl_in;
    endproperty
    a_ack_scl_low: assert property (p_ack_scl_low) else $error("sda pulled with scl high");
    property p_oe_steady;
        scl_in && $past(scl_in) |-> $stable(sda_oe);
    endproperty
    a_oe_steady: assert property (p_oe_steady) else $error("sda moved while scl high");
    property p_open_drain;
        sda_out == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("sda driven high");

    c_taken: cover property (s_taken);
endmodule // prmc_asserts

`default_nettype wire

// ### prmc_consts.vh
/*
 * proximity readout constants: register offsets, field positions,
 * reset values and timing figures.
 * assumes it is included by bare name from the design files.
 */
`ifndef PRMC_CONSTS_VH
`define PRMC_CONSTS_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define PRMC_OFS_RES_HIGH   8'h87
`define PRMC_OFS_RES_LOW    8'h88
`define PRMC_OFS_FREQ_SEL   8'h89
`define PRMC_OFS_MOD_TIMING 8'h8a

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define PRMC_FREQ_MSB       1
`define PRMC_FREQ_LSB       0
`define PRMC_DELAY_MSB      7
`define PRMC_DELAY_LSB      5
`define PRMC_DEAD_MSB       2
`define PRMC_DEAD_LSB       0

// ----------------------------------------------------------------------
// reset values and bus address
// ----------------------------------------------------------------------
`define PRMC_FREQ_RESET     2'h2
`define PRMC_DELAY_RESET    3'h0
`define PRMC_DEAD_RESET     3'h0
`define PRMC_RESULT_RESET   16'h0000
`define PRMC_BUS_ADDR       7'h13

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define PRMC_CLK_PERIOD_NS  4
`define PRMC_TEST_HALF_NS   160
`define PRMC_DELAY_STEP     4
`define PRMC_DEAD_STEP      2
`define PRMC_MEAS_CYCLES    4096

`endif

// ### prmc_host.sv
/*
 * bus host model: open-drain start, stop, byte transfer with pull-up.
 * assumes the testbench calls its tasks, all timed on falling edges.
 */
`timescale 1ns/1ns
`default_nettype none

module prmc_host (
    // clock
    input  wire logic clock,
    // bus pins
    input  wire logic sda_oe,
    output var  logic scl,
    output wire logic sda
);
    logic sda_drv; // host side of the wired-and line

    // pull-up: line is high unless someone pulls it low
    assign sda = sda_drv & ~sda_oe;

    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    task wt(input int n);
        repeat (n) @(negedge clock);
    endtask
    // scl phases kept at 10 cycles, above the 3 the synchroniser needs
    task start;
        sda_drv = 1'b0;
        wt(10);
        scl = 1'b0;
        wt(4);
    endtask
    // address write then repeated start before the read
    task rstart;
        sda_drv = 1'b1;
        wt(6);
        scl = 1'b1;
        wt(10);
        start;
    endtask
    task stop;
        sda_drv = 1'b0;
        wt(6);
        scl = 1'b1;
        wt(10);
        sda_drv = 1'b1;
        wt(10);
    endtask
    // data moves only well after scl falls, never near its edges
    task clk_bit(input logic b, output logic r);
        sda_drv = b;
        wt(6);
        scl = 1'b1;
        wt(10);
        r = sda;
        scl = 1'b0;
        wt(4);
    endtask
    task xfer(input logic [7:0] d, input logic last, output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], q[i]);
        clk_bit(last, r);
        ack = ~r;
    endtask
endmodule // prmc_host

`default_nettype wire

// ### prmc_modulator.v
/*
 * square-wave ir test signal generator and synchronous evaluator.
 * assumes ir_rx is an asynchronous pin and meas_start is a one-cycle
 * pulse from logic on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
`include "prmc_consts.vh"

module prmc_modulator #(
    parameter integer MEAS_CYCLES = `PRMC_MEAS_CYCLES
) (
    // clock and reset
    input  wire        clock,
    input  wire        nrst,
    // control
    input  wire        meas_start,
    input  wire [1:0]  freq_sel,
    input  wire [2:0]  delay_sel,
    input  wire [2:0]  dead_sel,
    // optical pins
    output reg         ir_led,
    input  wire        ir_rx,
    // result
    output reg  [15:0] result,
    output reg         meas_busy,
    output reg         meas_done
);
    // ------------------------------------------------------------------
    // derived timing
    // ------------------------------------------------------------------
    localparam [9:0] HALF0 = 10'd`PRMC_TEST_HALF_NS / 10'd`PRMC_CLK_PERIOD_NS; // 40 cycles
    localparam [9:0] DSTEP = 10'd`PRMC_DELAY_STEP;
    localparam [9:0] TSTEP = 10'd`PRMC_DEAD_STEP;

    reg        rx_meta;       // first sync stage, read only by rx_sync
    reg        rx_sync;       // ir input in clock domain
    reg  [1:0] sel_reg;       // frequency latched at start
    reg  [9:0] phase;         // led phase counter
    reg  [31:0] dur;          // cycles left in measurement
    reg signed [23:0] acc;    // correlation sum

    wire [9:0] half  = HALF0 << sel_reg;
    wire [9:0] per   = half << 1;
    wire [9:0] dly   = DSTEP * {7'h00, delay_sel};
    wire [9:0] dtime = TSTEP * {7'h00, dead_sel};
    // reference phase, lagging the led drive by the delay setting
    wire [9:0] q     = (phase >= dly) ? (phase - dly) : (phase + per - dly); // RULE6
    wire       ref_hi = q < half;
    // mask evaluation near both edges of the reference
    wire       masked = (q < dtime) || (q >= per - dtime) ||
                        ((q + dtime >= half) && (q < half + dtime)); // RULE7

    // ------------------------------------------------------------------
    // input synchroniser
    // ------------------------------------------------------------------
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rx_meta <= 1'b0;
            rx_sync <= 1'b0;
        end else begin
            rx_meta <= ir_rx;
            rx_sync <= rx_meta;
        end
    end

    // ------------------------------------------------------------------
    // measurement sequencer
    // ------------------------------------------------------------------
    // frequency is latched at start so a mid-run write cannot tear the wave
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sel_reg   <= `PRMC_FREQ_RESET;
            phase     <= 10'h000;
            dur       <= 32'h0000_0000;
            acc       <= 24'sh000000;
            ir_led    <= 1'b0;
            meas_busy <= 1'b0;
            meas_done <= 1'b0;
            result    <= `PRMC_RESULT_RESET;
        end else begin
            meas_done <= 1'b0;
            if (meas_start && !meas_busy) begin
                // new run
                sel_reg   <= freq_sel;
                phase     <= 10'h000;
                dur       <= MEAS_CYCLES;
                acc       <= 24'sh000000;
                meas_busy <= 1'b1;
                ir_led    <= 1'b1;
            end else if (meas_busy) begin
                // square wave at the selected frequency
                phase  <= (phase == per - 10'd1) ? 10'h000 : phase + 10'd1; // RULE5
                ir_led <= ((phase == per - 10'd1) ? 10'h000 : phase + 10'd1) < half; // RULE5
                // in phase counts up, out of phase counts down: ambient cancels
                if (!masked) begin
                    if (ref_hi && rx_sync)
                        acc <= acc + 24'sd1; // RULE5
                    else if (!ref_hi && rx_sync)
                        acc <= acc - 24'sd1; // RULE5
                end
                dur <= dur - 32'd1;
                if (dur == 32'd1) begin
                    meas_busy <= 1'b0;
                    meas_done <= 1'b1;
                    ir_led    <= 1'b0;
                    // clip to the 16-bit result range
                    if (acc < 24'sd0)
                        result <= 16'h0000;
                    else if (acc > 24'sd65535)
                        result <= 16'hffff;
                    else
                        result <= acc[15:0]; // RULE1
                end
            end
        end
    end
endmodule // prmc_modulator
`default_nettype wire

// ### prmc_top.v
/*
 * proximity result and modulator configuration block with its i2c
 * slave register port.
 * assumes scl/sda come from an open-drain bus with external pull-ups,
 * and meas_start comes from the measurement sequencer on this clock.
 */
//
// Contract
// RULE1: proximity result high at 87h, low 88h
// RULE2: result bytes read-only, writes ignored
// RULE3: frequency select field bits 1:0 at 89h
// RULE4: frequency select resets to code 2
// RULE5: drive led square wave, evaluate returned input
// RULE6: delay field bits 7:5 at 8Ah
// RULE7: dead time field bits 2:0 at 8Ah
// RULE8: host should program timing with 129
// RULE9: host addresses first, then reads
// RULE10: pointer advances after each read byte
// RULE11: unused bits read zero, writes ignored
`timescale 1ns/1ns
`default_nettype none
`include "prmc_consts.vh"

module prmc_top #(
    parameter [6:0]  BUS_ADDR    = `PRMC_BUS_ADDR,   // bus address
    parameter integer MEAS_CYCLES = `PRMC_MEAS_CYCLES
) (
    // clock and reset
    input  wire        clock,
    input  wire        nrst,
    // i2c pins
    input  wire        scl_in,
    input  wire        sda_in,
    output wire        sda_out,
    output wire        sda_oe,
    // measurement control
    input  wire        meas_start,
    output wire        meas_busy,
    output wire        meas_done,
    // optical pins
    output wire        ir_led,
    input  wire        ir_rx
);
    // ------------------------------------------------------------------
    // states, one-hot
    // ------------------------------------------------------------------
    localparam [6:0] ST_IDLE = 7'h01;
    localparam [6:0] ST_ADDR = 7'h02;
    localparam [6:0] ST_AACK = 7'h04;
    localparam [6:0] ST_WR   = 7'h08;
    localparam [6:0] ST_WACK = 7'h10;
    localparam [6:0] ST_RD   = 7'h20;
    localparam [6:0] ST_RACK = 7'h40;

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    reg  [1:0]  freq_reg;       // ir frequency code
    reg  [2:0]  delay_reg;      // modulation delay setting
    reg  [2:0]  dead_reg;       // modulation dead time setting
    reg  [7:0]  ptr_reg;        // register pointer
    reg  [6:0]  state_reg;      // bus state
    reg  [3:0]  bit_reg;        // bit counter
    reg  [7:0]  shift_reg;      // shift register
    reg         rw_reg;         // 1 for read transfer
    reg         first_reg;      // next write byte is the pointer
    reg         nack_reg;       // host refused more data
    reg         oe_reg;         // pull sda low
    reg         scl_meta;       // first sync stage
    reg         scl_sync;
    reg         scl_prev;
    reg         sda_meta;       // first sync stage
    reg         sda_sync;
    reg         sda_prev;
    wire [15:0] result;         // proximity result
    reg  [7:0]  rd_data;        // byte addressed by pointer

    wire scl_rise = scl_sync & ~scl_prev;
    wire scl_fall = ~scl_sync & scl_prev;
    wire bus_start = scl_sync & scl_prev & sda_prev & ~sda_sync;
    wire bus_stop  = scl_sync & scl_prev & ~sda_prev & sda_sync;

    // open drain: only ever pull low
    assign sda_out = 1'b0;
    assign sda_oe  = oe_reg;

    // ------------------------------------------------------------------
    // read map
    // ------------------------------------------------------------------
    // unused bits and unknown offsets read zero
    always @* begin
        case (ptr_reg)
            `PRMC_OFS_RES_HIGH:   rd_data = result[15:8];  // RULE1
            `PRMC_OFS_RES_LOW:    rd_data = result[7:0];   // RULE1
            `PRMC_OFS_FREQ_SEL:   rd_data = {6'h00, freq_reg}; // RULE11
            `PRMC_OFS_MOD_TIMING: rd_data = {delay_reg, 2'h0, dead_reg}; // RULE11
            default:              rd_data = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            scl_meta <= 1'b1;
            scl_sync <= 1'b1;
            scl_prev <= 1'b1;
            sda_meta <= 1'b1;
            sda_sync <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_meta <= scl_in;
            scl_sync <= scl_meta;
            scl_prev <= scl_sync;
            sda_meta <= sda_in;
            sda_sync <= sda_meta;
            sda_prev <= sda_sync;
        end
    end

    // ------------------------------------------------------------------
    // i2c slave engine and register writes
    // ------------------------------------------------------------------
    // samples on scl rise, changes sda on scl fall
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
            bit_reg   <= 4'h0;
            shift_reg <= 8'h00;
            rw_reg    <= 1'b0;
            first_reg <= 1'b0;
            nack_reg  <= 1'b0;
            oe_reg    <= 1'b0;
            ptr_reg   <= 8'h00;
            freq_reg  <= `PRMC_FREQ_RESET;  // RULE4
            delay_reg <= `PRMC_DELAY_RESET;
            dead_reg  <= `PRMC_DEAD_RESET;
        end else if (bus_start) begin
            // start or repeated start: pointer kept for the read
            state_reg <= ST_ADDR; // RULE9
            bit_reg   <= 4'h0;
            oe_reg    <= 1'b0;
        end else if (bus_stop) begin
            state_reg <= ST_IDLE;
            oe_reg    <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    oe_reg <= 1'b0;
                end
                ST_ADDR: begin
                    if (scl_rise && bit_reg != 4'h8) begin
                        shift_reg <= {shift_reg[6:0], sda_sync};
                        bit_reg   <= bit_reg + 4'h1;
                    end else if (scl_fall && bit_reg == 4'h8) begin
                        if (shift_reg[7:1] == BUS_ADDR) begin
                            // acknowledge own address only
                            oe_reg    <= 1'b1;
                            rw_reg    <= shift_reg[0];
                            state_reg <= ST_AACK;
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_AACK: begin
                    if (scl_fall) begin
                        bit_reg <= 4'h0;
                        if (rw_reg) begin
                            // first data bit goes out now
                            shift_reg <= {rd_data[6:0], 1'b0};
                            oe_reg    <= ~rd_data[7];
                            bit_reg   <= 4'h1;
                            ptr_reg   <= ptr_reg + 8'h01; // RULE10
                            state_reg <= ST_RD;
                        end else begin
                            oe_reg    <= 1'b0;
                            first_reg <= 1'b1;
                            state_reg <= ST_WR;
                        end
                    end
                end
                ST_WR: begin
                    if (scl_rise && bit_reg != 4'h8) begin
                        shift_reg <= {shift_reg[6:0], sda_sync};
                        bit_reg   <= bit_reg + 4'h1;
                    end else if (scl_fall && bit_reg == 4'h8) begin
                        oe_reg    <= 1'b1;
                        first_reg <= 1'b0;
                        state_reg <= ST_WACK;
                        if (first_reg) begin
                            ptr_reg <= shift_reg; // RULE9
                        end else begin
                            // result bytes and unused bits are not writable
                            if (ptr_reg == `PRMC_OFS_FREQ_SEL)
                                freq_reg <= shift_reg[`PRMC_FREQ_MSB:`PRMC_FREQ_LSB]; // RULE3
                            if (ptr_reg == `PRMC_OFS_MOD_TIMING) begin
                                delay_reg <= shift_reg[`PRMC_DELAY_MSB:`PRMC_DELAY_LSB]; // RULE6
                                dead_reg  <= shift_reg[`PRMC_DEAD_MSB:`PRMC_DEAD_LSB]; // RULE7
                            end
                            ptr_reg <= ptr_reg + 8'h01; // RULE2
                        end
                    end
                end
                ST_WACK: begin
                    if (scl_fall) begin
                        oe_reg    <= 1'b0;
                        bit_reg   <= 4'h0;
                        state_reg <= ST_WR;
                    end
                end
                ST_RD: begin
                    if (scl_fall) begin
                        if (bit_reg == 4'h8) begin
                            // release for the host acknowledge
                            oe_reg    <= 1'b0;
                            state_reg <= ST_RACK;
                        end else begin
                            oe_reg    <= ~shift_reg[7];
                            shift_reg <= {shift_reg[6:0], 1'b0};
                            bit_reg   <= bit_reg + 4'h1;
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        nack_reg <= sda_sync;
                    end else if (scl_fall) begin
                        if (nack_reg) begin
                            state_reg <= ST_IDLE;
                        end else begin
                            // next register follows without re-addressing
                            shift_reg <= {rd_data[6:0], 1'b0};
                            oe_reg    <= ~rd_data[7];
                            bit_reg   <= 4'h1;
                            ptr_reg   <= ptr_reg + 8'h01; // RULE10
                            state_reg <= ST_RD;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    oe_reg    <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // modulator and evaluator
    // ------------------------------------------------------------------
    prmc_modulator #(
        .MEAS_CYCLES (MEAS_CYCLES)
    ) u_mod (
        .clock      (clock),
        .nrst       (nrst),
        .meas_start (meas_start),
        .freq_sel   (freq_reg),
        .delay_sel  (delay_reg),
        .dead_sel   (dead_reg),
        .ir_led     (ir_led),
        .ir_rx      (ir_rx),
        .result     (result),
        .meas_busy  (meas_busy),
        .meas_done  (meas_done)
    );
endmodule // prmc_top
`default_nettype wire

// ### test_proximity_result_and_modulator_cfg.sv
/*
 * testbench: register table, led frequency, delay and dead time,
 * refused address and a second reset.
 * assumes the host model and checker files are compiled before it.
 */
`timescale 1ns/1ns
`default_nettype none

module test_proximity_result_and_modulator_cfg;
    localparam integer MEAS = 1024; // shortened run length
    logic        clock, nrst, scl, sda, sda_out, sda_oe;
    logic        meas_start, meas_busy, meas_done, ir_led, ir_rx;
    logic [15:0] lag_reg;  // 16-cycle optical path delay
    logic [7:0]  rb [4];   // bytes read back
    logic [15:0] r0, r1, r2;
    logic        a;
    int          hp, fail_count, samples_checked;
    // offset, written byte, expected read back
    logic [23:0] rows [8] = '{24'h890303, 24'h89ff03, 24'h890000, 24'h8affe7,
                              24'h8a8181, 24'h875500, 24'h88aa00, 24'h8bff00};

    prmc_top #(.MEAS_CYCLES(MEAS)) DUT (.clock(clock), .nrst(nrst), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .meas_start(meas_start), .meas_busy(meas_busy),
        .meas_done(meas_done), .ir_led(ir_led), .ir_rx(ir_rx));
    prmc_host host (.clock(clock), .sda_oe(sda_oe), .scl(scl), .sda(sda));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // echo the led back late so the delay setting has something to fix
    always @(negedge clock) begin
        lag_reg <= {lag_reg[14:0], ir_led};
        ir_rx <= lag_reg[15];
    end

    task chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wreg(input logic [7:0] ofs, input logic [7:0] d);
        logic [7:0] q;
        logic a0, a1, a2;
        host.start;
        host.xfer(8'h26, 1'b1, q, a0);
        host.xfer(ofs, 1'b1, q, a1);
        host.xfer(d, 1'b1, q, a2);
        host.stop;
        chk({13'h0, a0, a1, a2}, 16'h0007);
    endtask
    task rd(input logic [7:0] ofs, input int n);
        logic [7:0] t;
        logic a0, a1, a2;
        host.start;
        host.xfer(8'h26, 1'b1, t, a0);
        host.xfer(ofs, 1'b1, t, a1);
        host.rstart;
        host.xfer(8'h27, 1'b1, t, a2);
        for (int i = 0; i < n; i++) host.xfer(8'hff, i == n - 1, rb[i], a);
        host.stop;
        chk({13'h0, a0, a1, a2}, 16'h0007);
    endtask
    // one run: led high time and result read as a pair
    task meas(input logic [7:0] tim, input logic [7:0] fc, output logic [15:0] res);
        int k;
        wreg(8'h8a, tim);
        wreg(8'h89, fc);
        meas_start = 1'b1;
        @(negedge clock);
        meas_start = 1'b0;
        hp = 0;
        k = 0;
        while (ir_led === 1'b1 && hp < 2000) begin
            hp++;
            @(negedge clock);
        end
        while (meas_done !== 1'b1 && k < 5000) begin
            k++;
            @(negedge clock);
        end
        chk(16'(k < 5000), 16'h0001);
        rd(8'h87, 2);
        res = {rb[0], rb[1]};
    endtask
    task end_of_test;
        $display("summary: %0d mismatches in %0d checks", fail_count, samples_checked);
        if (fail_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // watchdog: the sequence needs about 36000 cycles
    initial begin
        repeat (90000) @(negedge clock);
        fail_count++;
        $display("watchdog expired");
        end_of_test;
    end

    initial begin
        nrst = 1'b0;
        meas_start = 1'b0;
        fail_count = 0;
        samples_checked = 0;
        repeat (8) @(negedge clock);
        nrst = 1'b1;
        host.wt(10);
        for (int i = 0; i < 8; i++) begin
            wreg(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16], 1);
            chk({8'h00, rb[0]}, {8'h00, rows[i][7:0]});
        end
        $display("register table test done");
        for (int c = 0; c < 4; c++) begin
            meas(8'h80, 8'(c), r0);
            chk(16'(hp), 16'(40 << c));
        end
        $display("frequency test done");
        meas(8'h00, 8'h00, r0);
        meas(8'h80, 8'h00, r1);
        meas(8'h87, 8'h00, r2);
        chk(16'(r1 > r0), 16'h0001);
        chk(16'(r2 < r1), 16'h0001);
        $display("delay and dead time test done");
        host.start;
        host.xfer(8'h28, 1'b1, rb[0], a);
        host.stop;
        chk(16'(a), 16'h0000);
        $display("foreign address test done");
        wreg(8'h89, 8'h01);
        wreg(8'h8a, 8'h81);
        nrst = 1'b0;
        repeat (3) @(negedge clock);
        nrst = 1'b1;
        host.wt(10);
        rd(8'h87, 4);
        chk({rb[0], rb[1]}, 16'h0000);
        chk({rb[2], rb[3]}, 16'h0200);
        $display("second reset test done");
        end_of_test;
    end
endmodule // test_proximity_result_and_modulator_cfg

bind prmc_top prmc_asserts #(.MEAS_CYCLES(MEAS_CYCLES)) u_prmc_chk (.clock(clock), .nrst(nrst),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .meas_start(meas_start),
    .meas_busy(meas_busy), .meas_done(meas_done), .ir_led(ir_led), .ir_rx(ir_rx));

`default_nettype wire
